/* rtl/addr_pkg.sv */
/*
  Shared constants and types for the program counter and data addressing block.
  Assumes a single core clock and that every user imports nothing, writing addr_pkg::name.
*/
package addr_pkg;

  // Program counter and program word widths.
  localparam int PC_W = 15;
  localparam int PM_WORD_W = 14;
  localparam int CALL_OFF_W = 11;
  localparam int BRA_OFF_W = 9;

  // Data memory geometry: bank number above the in-bank offset.
  localparam int NUM_BANKS = 32;
  localparam int BANK_BYTES = 128;
  localparam int BANK_W = 5;
  localparam int OFF_W = 7;
  localparam int DADDR_W = 12;

  // Layout of one bank.
  localparam int CORE_REGS = 12;
  localparam int SFR_FIRST = 12;
  localparam int SFR_BYTES = 20;
  localparam int GPR_FIRST = 32;
  localparam int GPR_BYTES = 80;
  localparam int COMMON_FIRST = 112;
  localparam int COMMON_BYTES = 16;

  // Pointer high-byte bit that steers an indirect access to program memory.
  localparam int PROG_SEL_BIT = 7;

  // Core register offsets, the same in every bank.
  localparam logic [6:0] OFF_IDP0 = 7'h00;
  localparam logic [6:0] OFF_IDP1 = 7'h01;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR0_LO = 7'h04;
  localparam logic [6:0] OFF_PTR0_HI = 7'h05;
  localparam logic [6:0] OFF_PTR1_LO = 7'h06;
  localparam logic [6:0] OFF_PTR1_HI = 7'h07;
  localparam logic [6:0] OFF_BSEL = 7'h08;
  localparam logic [6:0] OFF_WREG = 7'h09;
  localparam logic [6:0] OFF_PCLATCH = 7'h0a;
  localparam logic [6:0] OFF_INTCTL = 7'h0b;

  // Reset values.
  localparam logic [14:0] RST_PC = 15'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNIMPL_BYTE = 8'h00;

  // Timing counts in core clock cycles.
  localparam int ACC_LATENCY = 1;
  localparam int PM_EXTRA_CYCLES = 1;

  // What the program counter does when an instruction completes.
  typedef enum logic [2:0] {
    PC_NEXT,
    PC_CALL,
    PC_COMPUTED_CALL_WORKING,
    PC_BRW,
    PC_BRA,
    PC_RETURN,
    PC_HOLD
  } pc_op_t;

endpackage

/* rtl/data_ram.sv */
/*
  Byte array holding general RAM of every implemented bank plus the common RAM.
  Assumes one access per cycle: synchronous write, combinational read.
*/
`timescale 1ns/1ps
module data_ram #(
  parameter int DEPTH = 656,
  parameter int IDX_W = 10
) (
  input wire logic mclk_i,
  input wire logic we_i,
  input wire logic [IDX_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [DEPTH];

  // Contents are not reset; software must initialise RAM before use.
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[addr_i];

endmodule

/* rtl/pc_and_data_addressing.sv */
/*
  Address generation for an 8-bit core: program counter, banked data memory,
  core registers and indirect reads of program memory.
  Assumes the decoder on the same clock issues at most one file access at a time,
  waits while busy_o is high, and a program memory that answers in the same cycle as pm_rd_o.
*/
// How it works
// - Pointer high bit 7 selects program memory
// - Indirect program read keeps low eight bits
// - Indirect writes never alter program memory
// - Program memory indirect read takes extra cycle
// - Thirty-two banks of 128 bytes
// - Core, special, general and common regions
// - Direct access uses bank select register
// - Unimplemented locations read as zero
// - Twelve-bit address: bank over offset
// - First twelve offsets are core registers
// - Program counter is fifteen bits
// - Every reset clears program counter
// - Low byte readable; high bits via latch
// - Low byte write also loads latch bits
// - Absolute call mixes operand and latch
// - Computed call uses working and latch
// - Branch adds unsigned working register
// - Relative branch adds signed operand
// - Branches span all fifteen bits
// - Stack push and pop keep latch
`timescale 1ns/1ps
module pc_and_data_addressing #(
  parameter int GPR_BANKS = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic instr_done_i,
  input wire addr_pkg::pc_op_t pc_op_i,
  input wire logic [10:0] operand_i,
  input wire logic [14:0] ret_addr_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_to_w_i,
  input wire logic [6:0] acc_offset_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic [13:0] pm_data_i,
  output logic [14:0] pc_o,
  output logic [7:0] rdata_o,
  output logic acc_done_o,
  output logic busy_o,
  output logic pm_rd_o,
  output logic [14:0] pm_addr_o,
  output logic [7:0] wreg_o,
  output logic [4:0] bsr_o
);

  localparam int RAM_DEPTH = GPR_BANKS * addr_pkg::GPR_BYTES + addr_pkg::COMMON_BYTES;
  localparam int IDX_W = $clog2(RAM_DEPTH);

  // Refuse bank counts the address split cannot reach.
  initial begin
    if (GPR_BANKS < 1 || GPR_BANKS > addr_pkg::NUM_BANKS) begin
      $error("GPR_BANKS must lie between 1 and the bank count");
    end
  end

  typedef enum logic {
    ST_IDLE,
    ST_PM_WAIT
  } acc_state_t;

  acc_state_t state_reg;
  logic [7:0] status_reg;
  logic [15:0] ptr0_reg;
  logic [15:0] ptr1_reg;
  logic [4:0] bsel_reg;
  logic [7:0] wreg_reg;
  logic [6:0] pc_high_latch_reg;
  logic [7:0] intctl_reg;
  logic pm_to_w_reg;
  logic [7:0] rdata_reg;
  logic done_reg;
  logic pm_rd_reg;
  logic [14:0] pm_addr_reg;

  logic take;
  logic via_ptr;
  logic [15:0] ptr_sel;
  logic to_prog;
  logic [11:0] daddr;
  logic [4:0] bank;
  logic [6:0] off;
  logic [IDX_W:0] ram_hit_idx;
  logic ram_hit;
  logic [7:0] ram_rdata;
  logic [7:0] rd_val;
  logic core_we;
  logic pcl_we;
  logic [14:0] pc_now;

  // Maps a bank and offset onto the RAM array; the top bit flags a hit.
  function automatic logic [IDX_W:0] ram_index(input logic [4:0] b, input logic [6:0] o);
    int idx;
    logic hit;
    idx = 0;
    hit = 1'b0;
    if (o >= 7'(addr_pkg::COMMON_FIRST)) begin
      idx = GPR_BANKS * addr_pkg::GPR_BYTES + int'(o) - addr_pkg::COMMON_FIRST;
      hit = 1'b1;
    end else if (o >= 7'(addr_pkg::GPR_FIRST) && int'(b) < GPR_BANKS) begin
      idx = int'(b) * addr_pkg::GPR_BYTES + int'(o) - addr_pkg::GPR_FIRST;
      hit = 1'b1;
    end
    return {hit, IDX_W'(idx)};
  endfunction

  // A request is taken only while no program memory read is pending.
  assign take = acc_valid_i && (state_reg == ST_IDLE);

  // Offsets 0 and 1 are the indirect data ports of the two pointers.
  assign via_ptr = (acc_offset_i == addr_pkg::OFF_IDP0) || (acc_offset_i == addr_pkg::OFF_IDP1);
  assign ptr_sel = acc_offset_i[0] ? ptr1_reg : ptr0_reg;
  assign to_prog = via_ptr && ptr_sel[addr_pkg::PROG_SEL_BIT + 8];

  // Direct accesses take the bank from the select register.
  assign daddr = via_ptr ? ptr_sel[11:0] : {bsel_reg, acc_offset_i};
  assign bank = daddr[11:7];
  assign off = daddr[6:0];

  assign ram_hit_idx = ram_index(bank, off);
  assign ram_hit = ram_hit_idx[IDX_W];

  // A pointer that lands on a port reads zero, which avoids a recursive access.
  always_comb begin
    rd_val = addr_pkg::UNIMPL_BYTE;
    if (off < 7'(addr_pkg::CORE_REGS)) begin
      case (off)
        addr_pkg::OFF_PCL: rd_val = pc_now[7:0];
        addr_pkg::OFF_STATUS: rd_val = status_reg;
        addr_pkg::OFF_PTR0_LO: rd_val = ptr0_reg[7:0];
        addr_pkg::OFF_PTR0_HI: rd_val = ptr0_reg[15:8];
        addr_pkg::OFF_PTR1_LO: rd_val = ptr1_reg[7:0];
        addr_pkg::OFF_PTR1_HI: rd_val = ptr1_reg[15:8];
        addr_pkg::OFF_BSEL: rd_val = {3'h0, bsel_reg};
        addr_pkg::OFF_WREG: rd_val = wreg_reg;
        addr_pkg::OFF_PCLATCH: rd_val = {1'b0, pc_high_latch_reg};
        addr_pkg::OFF_INTCTL: rd_val = intctl_reg;
        default: rd_val = addr_pkg::UNIMPL_BYTE;
      endcase
    end else if (ram_hit) begin
      rd_val = ram_rdata;
    end
  end

  // Core register writes happen in any bank; program memory is never a target.
  assign core_we = take && acc_write_i && !to_prog && (off < 7'(addr_pkg::CORE_REGS));
  assign pcl_we = core_we && (off == addr_pkg::OFF_PCL);

  data_ram #(
    .DEPTH(RAM_DEPTH),
    .IDX_W(IDX_W)
  ) u_ram (
    .mclk_i(mclk_i),
    .we_i(take && acc_write_i && !to_prog && ram_hit),
    .addr_i(ram_hit_idx[IDX_W-1:0]),
    .wdata_i(acc_wdata_i),
    .rdata_o(ram_rdata)
  );

  pc_counter u_pc (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .step_i(instr_done_i),
    .op_i(pc_op_i),
    .operand_i(operand_i),
    .wreg_i(wreg_reg),
    .pc_high_latch_i(pc_high_latch_reg),
    .pcl_we_i(pcl_we),
    .pcl_wdata_i(acc_wdata_i),
    .ret_addr_i(ret_addr_i),
    .pc_o(pc_now)
  );

  // Access sequencing: a program memory read parks here for its extra cycle.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (take && to_prog && !acc_write_i) begin
            state_reg <= ST_PM_WAIT;
          end
        end
        ST_PM_WAIT: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Program memory port: the address is the pointer without its select bit.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pm_rd_reg <= 1'b0;
      pm_addr_reg <= addr_pkg::RST_PC;
      pm_to_w_reg <= 1'b0;
    end else begin
      pm_rd_reg <= take && to_prog && !acc_write_i;
      if (take && to_prog && !acc_write_i) begin
        pm_addr_reg <= ptr_sel[14:0];
        pm_to_w_reg <= acc_to_w_i;
      end
    end
  end

  // Read data and completion; writes also complete after one cycle.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= addr_pkg::RST_BYTE;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (state_reg == ST_PM_WAIT) begin
        rdata_reg <= pm_data_i[7:0];
        done_reg <= 1'b1;
      end else if (take && !(to_prog && !acc_write_i)) begin
        rdata_reg <= acc_write_i ? rdata_reg : rd_val;
        done_reg <= 1'b1;
      end
    end
  end

  // Status byte is plain storage here; its flags are driven elsewhere.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      status_reg <= addr_pkg::RST_BYTE;
    end else if (core_we && off == addr_pkg::OFF_STATUS) begin
      status_reg <= acc_wdata_i;
    end
  end

  // The two pointers, written a byte at a time.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ptr0_reg <= {addr_pkg::RST_BYTE, addr_pkg::RST_BYTE};
      ptr1_reg <= {addr_pkg::RST_BYTE, addr_pkg::RST_BYTE};
    end else if (core_we) begin
      case (off)
        addr_pkg::OFF_PTR0_LO: ptr0_reg[7:0] <= acc_wdata_i;
        addr_pkg::OFF_PTR0_HI: ptr0_reg[15:8] <= acc_wdata_i;
        addr_pkg::OFF_PTR1_LO: ptr1_reg[7:0] <= acc_wdata_i;
        addr_pkg::OFF_PTR1_HI: ptr1_reg[15:8] <= acc_wdata_i;
        default: ptr0_reg <= ptr0_reg;
      endcase
    end
  end

  // Bank select keeps only the bits that name one of the banks.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      bsel_reg <= 5'h00;
    end else if (core_we && off == addr_pkg::OFF_BSEL) begin
      bsel_reg <= acc_wdata_i[4:0];
    end
  end

  // Working register: file writes, loaded reads and program memory reads.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      wreg_reg <= addr_pkg::RST_BYTE;
    end else if (state_reg == ST_PM_WAIT) begin
      if (pm_to_w_reg) begin
        wreg_reg <= pm_data_i[7:0];
      end
    end else if (core_we && off == addr_pkg::OFF_WREG) begin
      wreg_reg <= acc_wdata_i;
    end else if (take && !acc_write_i && acc_to_w_i && !to_prog) begin
      wreg_reg <= rd_val;
    end
  end

  // The high latch changes only by a file write, never by calls or returns.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_high_latch_reg <= 7'h00;
    end else if (core_we && off == addr_pkg::OFF_PCLATCH) begin
      pc_high_latch_reg <= acc_wdata_i[6:0];
    end
  end

  // Interrupt control byte is stored here and used by other logic.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      intctl_reg <= addr_pkg::RST_BYTE;
    end else if (core_we && off == addr_pkg::OFF_INTCTL) begin
      intctl_reg <= acc_wdata_i;
    end
  end

  assign pc_o = pc_now;
  assign rdata_o = rdata_reg;
  assign acc_done_o = done_reg;
  assign busy_o = (state_reg == ST_PM_WAIT);
  assign pm_rd_o = pm_rd_reg;
  assign pm_addr_o = pm_addr_reg;
  assign wreg_o = wreg_reg;
  assign bsr_o = bsel_reg;

endmodule

/* rtl/pc_counter.sv */
/*
  Fifteen-bit program counter with every way of loading it.
  Assumes the core pulses step_i once per completed instruction and holds op_i and operand_i with it.
*/
`timescale 1ns/1ps
module pc_counter (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic step_i,
  input wire addr_pkg::pc_op_t op_i,
  input wire logic [10:0] operand_i,
  input wire logic [7:0] wreg_i,
  input wire logic [6:0] pc_high_latch_i,
  input wire logic pcl_we_i,
  input wire logic [7:0] pcl_wdata_i,
  input wire logic [14:0] ret_addr_i,
  output logic [14:0] pc_o
);

  logic [14:0] pc_reg;
  logic [14:0] pc_next;
  logic [14:0] pc_inc;

  // Branch targets use all bits, so page crossings need no latch.
  assign pc_inc = 15'(pc_reg + 15'h0001);

  // Next value selection; a write of the low byte beats the instruction flow.
  always_comb begin
    pc_next = pc_reg;
    if (pcl_we_i) begin
      pc_next = {pc_high_latch_i, pcl_wdata_i};
    end else if (step_i) begin
      case (op_i)
        addr_pkg::PC_NEXT: pc_next = pc_inc;
        addr_pkg::PC_CALL: pc_next = {pc_high_latch_i[6:3], operand_i};
        addr_pkg::PC_COMPUTED_CALL_WORKING: pc_next = {pc_high_latch_i, wreg_i};
        addr_pkg::PC_BRW: pc_next = 15'(pc_inc + {7'h00, wreg_i});
        addr_pkg::PC_BRA: pc_next = 15'(pc_inc + {{6{operand_i[8]}}, operand_i[8:0]});
        addr_pkg::PC_RETURN: pc_next = ret_addr_i;
        default: pc_next = pc_reg;
      endcase
    end
  end

  // Any reset clears the counter.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_reg <= addr_pkg::RST_PC;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign pc_o = pc_reg;

endmodule

/* tb/addr_checker_properties.sv */
/*
  Port assertions for the program counter and data addressing block.
  Assumes one core clock and the asynchronous active-high reset of the block.
*/
`timescale 1ns/1ps
module addr_checker (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic instr_done_i,
  input wire addr_pkg::pc_op_t pc_op_i,
  input wire logic [10:0] operand_i,
  input wire logic [14:0] ret_addr_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [6:0] acc_offset_i,
  input wire logic [13:0] pm_data_i,
  input wire logic [14:0] pc_o,
  input wire logic [7:0] rdata_o,
  input wire logic acc_done_o,
  input wire logic busy_o,
  input wire logic pm_rd_o,
  input wire logic [7:0] wreg_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // An OFF_PCL write wins over the step, so steps are only judged without one.
  logic take;
  logic step;
  logic [14:0] bra_off;
  logic [7:0] pm_low;
  assign take = acc_valid_i && !busy_o;
  assign step = instr_done_i && !(take && acc_write_i && acc_offset_i == addr_pkg::OFF_PCL);
  assign bra_off = {{6{operand_i[8]}}, operand_i[8:0]};
  assign pm_low = pm_data_i[7:0];
  // A program word read: strobe, then completion one cycle later.
  sequence s_prog_read;
    pm_rd_o ##1 acc_done_o;
  endsequence
  a_prog_extra_cycle: assert property (pm_rd_o |-> busy_o ##1 (acc_done_o && !busy_o))
    else $error("program read did not finish one cycle late");
  a_prog_low_byte: assert property (s_prog_read |-> rdata_o == $past(pm_low))
    else $error("program read data is not the low byte");
  a_write_no_fetch: assert property (take && acc_write_i |=> acc_done_o && !pm_rd_o)
    else $error("write did not complete plainly");
  a_read_answer: assert property (take && !acc_write_i |=> acc_done_o != pm_rd_o)
    else $error("read answered neither directly nor by fetch");
  a_done_pulse: assert property (acc_done_o |=> !acc_done_o)
    else $error("done held beyond one cycle");
  a_pc_next: assert property (step && pc_op_i == addr_pkg::PC_NEXT |=> pc_o == $past(pc_o) + 15'h0001)
    else $error("counter did not advance by one");
  a_pc_brw: assert property (step && pc_op_i == addr_pkg::PC_BRW |=>
    pc_o == $past(pc_o) + 15'h0001 + {7'h00, $past(wreg_o)})
    else $error("branch by working target wrong");
  a_pc_bra: assert property (step && pc_op_i == addr_pkg::PC_BRA |=>
    pc_o == $past(pc_o) + 15'h0001 + $past(bra_off))
    else $error("relative branch target wrong");
  a_pc_return: assert property (step && pc_op_i == addr_pkg::PC_RETURN |=> pc_o == $past(ret_addr_i))
    else $error("return address not loaded");
  a_pc_hold: assert property (step && pc_op_i == addr_pkg::PC_HOLD |=> $stable(pc_o))
    else $error("counter moved on hold");
endmodule

bind pc_and_data_addressing addr_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
  .instr_done_i(instr_done_i), .pc_op_i(pc_op_i), .operand_i(operand_i), .ret_addr_i(ret_addr_i),
  .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_offset_i(acc_offset_i),
  .pm_data_i(pm_data_i), .pc_o(pc_o), .rdata_o(rdata_o), .acc_done_o(acc_done_o),
  .busy_o(busy_o), .pm_rd_o(pm_rd_o), .wreg_o(wreg_o));

/* tb/tb.sv */
/*
  Self-checking bench for the address block: PC loads, banked access and indirect reads.
  Assumes the bench plays core and program memory, holding pm_data_i steady around reads.
*/
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic instr_done_i = 1'b0;
  addr_pkg::pc_op_t pc_op_i = addr_pkg::PC_NEXT;
  logic [10:0] operand_i = 11'h000;
  logic [14:0] ret_addr_i = 15'h0000;
  logic acc_valid_i = 1'b0;
  logic acc_write_i = 1'b0;
  logic acc_to_w_i = 1'b0;
  logic [6:0] acc_offset_i = 7'h00;
  logic [7:0] acc_wdata_i = 8'h00;
  logic [13:0] pm_data_i = 14'h0000;
  logic [14:0] pc_o;
  logic [14:0] pm_addr_o;
  logic [7:0] rdata_o;
  logic [7:0] wreg_o;
  logic [4:0] bsr_o;
  logic acc_done_o;
  logic busy_o;
  logic pm_rd_o;
  int miscompares = 0;
  int num_checks = 0;
  int lat;
  logic [7:0] q;
  logic [14:0] e;

  pc_and_data_addressing DUT (.mclk_i(mclk_i), .reset_i(reset_i), .instr_done_i(instr_done_i),
    .pc_op_i(pc_op_i), .operand_i(operand_i), .ret_addr_i(ret_addr_i), .acc_valid_i(acc_valid_i),
    .acc_write_i(acc_write_i), .acc_to_w_i(acc_to_w_i), .acc_offset_i(acc_offset_i),
    .acc_wdata_i(acc_wdata_i), .pm_data_i(pm_data_i), .pc_o(pc_o), .rdata_o(rdata_o),
    .acc_done_o(acc_done_o), .busy_o(busy_o), .pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o),
    .wreg_o(wreg_o), .bsr_o(bsr_o));

  // Core clock of 8 ns.
  always #4 mclk_i = ~mclk_i;

  // Compare one value and count it; unknowns never match.
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One file access; the wait for done is bounded so a hang ends the run.
  task automatic acc(input logic wr, input logic tw, input logic [6:0] off, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    acc_valid_i <= 1'b1;
    acc_write_i <= wr;
    acc_to_w_i <= tw;
    acc_offset_i <= off;
    acc_wdata_i <= d;
    @(posedge mclk_i);
    acc_valid_i <= 1'b0;
    @(negedge mclk_i);
    while (acc_done_o !== 1'b1 && n < 4) begin
      @(negedge mclk_i);
      n++;
    end
    lat = n + 1;
    q = rdata_o;
    if (n == 4) begin
      miscompares++;
      $display("[ERR] acc_done_o expected 1 seen 0");
      end_of_test();
    end
  endtask

  // One completed instruction; RETURN pops {4'h4, o}.
  task automatic step(input addr_pkg::pc_op_t op, input logic [10:0] o);
    @(posedge mclk_i);
    instr_done_i <= 1'b1;
    pc_op_i <= op;
    operand_i <= o;
    ret_addr_i <= {4'h4, o};
    @(posedge mclk_i);
    instr_done_i <= 1'b0;
    @(negedge mclk_i);
  endtask

  // Everything visible starts at zero after reset.
  task automatic t_reset();
    @(negedge mclk_i);
    chk("pc_o", 15'h0000, pc_o);
    chk("wreg_o", 15'h0000, {7'h00, wreg_o});
    chk("bsr_o", 15'h0000, {10'h000, bsr_o});
    chk("rdata_o", 15'h0000, {7'h00, rdata_o});
    chk("pm_addr_o", 15'h0000, pm_addr_o);
    chk("flags", 15'h0000, {12'h000, acc_done_o, busy_o, pm_rd_o});
    $display("test reset done");
  endtask

  // Every way of loading the counter, including wrap and page crossing.
  task automatic t_pc();
    acc(1'b1, 1'b0, addr_pkg::OFF_PCLATCH, 8'h7f);
    acc(1'b1, 1'b0, addr_pkg::OFF_PCL, 8'hff);
    chk("pcl write", 15'h7fff, pc_o);
    acc(1'b0, 1'b0, addr_pkg::OFF_PCL, 8'h00);
    chk("pcl read", 15'h00ff, {7'h00, q});
    step(addr_pkg::PC_NEXT, 11'h000);
    chk("wrap", 15'h0000, pc_o);
    acc(1'b1, 1'b0, addr_pkg::OFF_PCLATCH, 8'h2d);
    step(addr_pkg::PC_CALL, 11'h5a3);
    chk("call", {4'h5, 11'h5a3}, pc_o);
    acc(1'b1, 1'b0, addr_pkg::OFF_WREG, 8'hf0);
    step(addr_pkg::PC_COMPUTED_CALL_WORKING, 11'h000);
    e = {7'h2d, 8'hf0};
    chk("computed_call_working", e, pc_o);
    step(addr_pkg::PC_BRW, 11'h000);
    e = e + 15'h0001 + 15'h00f0;
    chk("brw", e, pc_o);
    step(addr_pkg::PC_BRA, 11'h100);
    e = e + 15'h0001 - 15'h0100;
    chk("bra", e, pc_o);
    step(addr_pkg::PC_HOLD, 11'h000);
    chk("hold", e, pc_o);
    step(addr_pkg::PC_RETURN, 11'h321);
    chk("return", {4'h4, 11'h321}, pc_o);
    acc(1'b0, 1'b0, addr_pkg::OFF_PCLATCH, 8'h00);
    chk("latch kept", 15'h002d, {7'h00, q});
    $display("test pc done");
  endtask

  // Bank selection, common RAM, core registers and unimplemented places.
  task automatic t_bank();
    acc(1'b1, 1'b0, addr_pkg::OFF_BSEL, 8'h01);
    acc(1'b1, 1'b0, 7'h20, 8'ha5);
    acc(1'b1, 1'b0, addr_pkg::OFF_BSEL, 8'h02);
    acc(1'b1, 1'b0, 7'h20, 8'h5a);
    acc(1'b1, 1'b0, 7'h70, 8'h3c);
    acc(1'b1, 1'b0, addr_pkg::OFF_BSEL, 8'h01);
    chk("bsr_o", 15'h0001, {10'h000, bsr_o});
    acc(1'b0, 1'b0, 7'h20, 8'h00);
    chk("bank ram", 15'h00a5, {7'h00, q});
    acc(1'b0, 1'b0, 7'h7f - 7'h0f, 8'h00);
    chk("common ram", 15'h003c, {7'h00, q});
    acc(1'b1, 1'b0, addr_pkg::OFF_BSEL, 8'h08);
    acc(1'b1, 1'b0, 7'h20, 8'h99);
    acc(1'b0, 1'b0, 7'h20, 8'h00);
    chk("no ram", 15'h0000, {7'h00, q});
    acc(1'b0, 1'b0, 7'h0c, 8'h00);
    chk("sfr gap", 15'h0000, {7'h00, q});
    acc(1'b1, 1'b0, addr_pkg::OFF_BSEL, 8'h1f);
    acc(1'b0, 1'b0, addr_pkg::OFF_WREG, 8'h00);
    chk("core reg", 15'h00f0, {7'h00, q});
    $display("test bank done");
  endtask

  // Pointer reads of program and data memory.
  task automatic t_ind();
    acc(1'b1, 1'b0, addr_pkg::OFF_PTR0_HI, 8'h81);
    acc(1'b1, 1'b0, addr_pkg::OFF_PTR0_LO, 8'h23);
    @(posedge mclk_i);
    pm_data_i <= 14'h3abc;
    acc(1'b0, 1'b1, addr_pkg::OFF_IDP0, 8'h00);
    chk("prog lat", 15'h0002, lat[14:0]);
    chk("pm_addr_o", 15'h0123, pm_addr_o);
    chk("prog byte", 15'h00bc, {7'h00, q});
    chk("prog w", 15'h00bc, {7'h00, wreg_o});
    acc(1'b1, 1'b0, addr_pkg::OFF_IDP0, 8'h77);
    chk("prog wr lat", 15'h0001, lat[14:0]);
    acc(1'b1, 1'b0, addr_pkg::OFF_PTR1_HI, 8'h01);
    acc(1'b1, 1'b0, addr_pkg::OFF_PTR1_LO, 8'h20);
    acc(1'b0, 1'b0, addr_pkg::OFF_IDP1, 8'h00);
    chk("ptr data", 15'h005a, {7'h00, q});
    $display("test indirect done");
  endtask

  // Hold reset for 12 cycles, then run each scenario.
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset();
    t_pc();
    t_bank();
    t_ind();
    end_of_test();
  end
endmodule
